/* design/fsp_regs.vh */
// fsp_regs.vh: command codes, map layout and timing for the flash sector protection block
// assumes: included by bare name; definitions only
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
`define FSP_PFX0          8'h3D
`define FSP_PFX1          8'h2A
`define FSP_PFX2          8'h7F
`define FSP_CODE_ENABLE   8'hA9
`define FSP_CODE_DISABLE  8'h9A
`define FSP_CODE_ERASE    8'hCF
`define FSP_CODE_PROGRAM  8'hFC
`define FSP_OP_READ       8'h32
`define FSP_MAP_BYTES     8
`define FSP_MAP_ERASED    8'hFF
`define FSP_MAP_CLEAR     8'h00
`define FSP_SUB_A_HI      7
`define FSP_SUB_A_LO      6
`define FSP_SUB_B_HI      5
`define FSP_SUB_B_LO      4
`define FSP_CLK_MHZ       50
`define FSP_ERASE_TIME_US 1000
`define FSP_PROG_TIME_US  1000
`define FSP_ASSERT_NS     200
`define FSP_RELEASE_NS    200
`define FSP_ERASE_CYC     (`FSP_ERASE_TIME_US * `FSP_CLK_MHZ)
`define FSP_PROG_CYC      (`FSP_PROG_TIME_US * `FSP_CLK_MHZ)
`define FSP_ASSERT_CYC    ((`FSP_ASSERT_NS * `FSP_CLK_MHZ) / 1000)
`define FSP_RELEASE_CYC   ((`FSP_RELEASE_NS * `FSP_CLK_MHZ) / 1000)
`endif

/* design/fsp_pin_filter.v */
// fsp_pin_filter.v: three-stage synchroniser and stability filter for the write-protect pin
// assumes: pin is asynchronous to mclk_in; reset synchronous active low
`timescale 1ns/1ps
`default_nettype none
module fsp_pin_filter #(
  parameter integer STABLE_CYC = 10,
  parameter integer CNT_W      = 8
) (
  input  wire mclk_in,
  input  wire rst_b_in,
  input  wire pin_in,
  output reg  level_out
);
  reg             s1_reg;
  reg             s2_reg;
  reg             s3_reg;
  reg [CNT_W-1:0] cnt_reg;

  // synchroniser chain; only s2 and s3 are compared
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level is taken only after it stays different for STABLE_CYC cycles
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cnt_reg   <= {CNT_W{1'b0}};
      level_out <= 1'b1;
    end else if (s2_reg != s3_reg || s3_reg == level_out) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (cnt_reg >= STABLE_CYC[CNT_W-1:0] - 1'b1) begin
      cnt_reg   <= {CNT_W{1'b0}};
      level_out <= s3_reg; // glitch-free change
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* design/fsp_protect.v */
// fsp_protect.v: sector protection logic of a serial flash (map, commands, write-protect pin)
// assumes: spi pins are sampled on mclk_in, which runs far faster than the serial clock
//
// Contract
// - pin asserted blocks protected sectors and map
// - pin overrides software only for sectors
// - pin assert enables protection within limit
// - pin release disables unless software enabled
// - software enable survives pin release
// - disable command ignored while pin asserted
// - pin glitches filtered out
// - eight map bytes, byte n sector n
// - FF protects, 00 unprotects sectors 1-7
// - byte 0 bits 7:6 and 5:4 subsectors
// - map starts all zeros
// - erase after chip select release, busy shown
// - erase sets all FF, refused while pin asserted or busy
// - program eight bytes, self-timed, busy shown
// - ninth data byte wraps to location 0
// - programming allowed whatever software state
// - programming overwrites first sram buffer
// - read opcode, three dummies, bytes 0-7 out
// - chip select release floats serial out
// - enable code sets software enable
// - disable code clears software enable
// - software enable cleared after power up
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.vh"
module fsp_protect #(
  parameter integer ERASE_CYC = `FSP_ERASE_CYC,
  parameter integer PROG_CYC  = `FSP_PROG_CYC
) (
  input  wire       mclk_in,
  input  wire       rst_b_in,
  input  wire       sck_in,
  input  wire       cs_b_in,
  input  wire       si_in,
  input  wire       wp_b_in,
  input  wire [3:0] sect_req_in,
  input  wire       sub_req_in,
  output reg        so_out,
  output reg        so_oe_b_out,
  output reg        busy_out,
  output reg        prot_en_out,
  output reg        sect_prot_out,
  output reg        map_lock_out,
  output reg        buf1_we_out,
  output reg  [2:0] buf1_addr_out,
  output reg  [7:0] buf1_data_out
);
  localparam ST_CMD  = 3'h0;
  localparam ST_PDAT = 3'h1;
  localparam ST_RDAT = 3'h2;
  localparam ST_IGN  = 3'h3;
  localparam T_W     = 26;

  reg  [7:0]     map_reg [0:`FSP_MAP_BYTES-1];
  reg  [7:0]     stage_reg [0:`FSP_MAP_BYTES-1];
  reg  [2:0]     sck_s_reg;
  reg  [2:0]     cs_s_reg;
  reg  [2:0]     si_s_reg;
  reg  [2:0]     st_reg;
  reg  [2:0]     bit_reg;
  reg  [7:0]     sh_reg;
  reg  [1:0]     nb_reg;
  reg  [2:0]     wptr_reg;
  reg  [2:0]     rptr_reg;
  reg  [7:0]     out_reg;
  reg  [1:0]     pend_reg;
  reg            sw_en_reg;
  reg            ers_reg;
  reg            prg_reg;
  reg            rd_reg;
  reg  [T_W-1:0] tmr_reg;
  reg  [7:0]     rx_next;
  wire           wp_lvl;
  wire           wp_on;
  wire           sck_rise;
  wire           sck_fall;
  wire           cs_low;
  wire           cs_rise;
  wire           byte_done;
  integer        i;

  localparam PD_NONE = 2'h0;
  localparam PD_EN   = 2'h1;
  localparam PD_DIS  = 2'h2;
  localparam PD_ERS  = 2'h3;

  // stable write-protect level, filtered over the assert delay
  fsp_pin_filter #(
    .STABLE_CYC (`FSP_ASSERT_CYC),
    .CNT_W      (8)
  ) u_wp (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    (wp_b_in),
    .level_out (wp_lvl)
  );
  assign wp_on = ~wp_lvl;

  // spi pins through three flip-flops; edges when stages 2 and 3 differ
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      sck_s_reg <= 3'h0;
      cs_s_reg  <= 3'h7;
      si_s_reg  <= 3'h0;
    end else begin
      sck_s_reg <= {sck_s_reg[1:0], sck_in};
      cs_s_reg  <= {cs_s_reg[1:0], cs_b_in};
      si_s_reg  <= {si_s_reg[1:0], si_in};
    end
  end
  assign sck_rise  = sck_s_reg[1] & ~sck_s_reg[2];
  assign sck_fall  = ~sck_s_reg[1] & sck_s_reg[2];
  assign cs_low    = ~cs_s_reg[2];
  assign cs_rise   = cs_s_reg[1] & ~cs_s_reg[2];
  assign byte_done = cs_low & sck_rise & (bit_reg == 3'h7);

  // assembled byte including the bit now being sampled
  always @* begin
    rx_next = {sh_reg[6:0], si_s_reg[2]};
  end

  // frame decoder, map storage, self-timed erase and program
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_reg      <= ST_CMD;
      bit_reg     <= 3'h0;
      sh_reg      <= 8'h00;
      nb_reg      <= 2'h0;
      wptr_reg    <= 3'h0;
      rptr_reg    <= 3'h0;
      pend_reg    <= PD_NONE;
      sw_en_reg   <= 1'b0; // cleared at power up
      ers_reg     <= 1'b0;
      prg_reg     <= 1'b0;
      rd_reg      <= 1'b0;
      tmr_reg     <= {T_W{1'b0}};
      buf1_we_out <= 1'b0;
      buf1_addr_out <= 3'h0;
      buf1_data_out <= 8'h00;
      for (i = 0; i < `FSP_MAP_BYTES; i = i + 1) begin
        map_reg[i]   <= `FSP_MAP_CLEAR; // shipped all zeros
        stage_reg[i] <= `FSP_MAP_CLEAR;
      end
    end else begin
      buf1_we_out <= 1'b0;
      // self-timed cycles; map updates at the end
      if (ers_reg || prg_reg) begin
        if (tmr_reg == {T_W{1'b0}}) begin
          for (i = 0; i < `FSP_MAP_BYTES; i = i + 1) begin
            if (ers_reg)
              map_reg[i] <= `FSP_MAP_ERASED; // erase marks all protected
            else
              map_reg[i] <= map_reg[i] & stage_reg[i]; // program clears bits only
          end
          ers_reg <= 1'b0;
          prg_reg <= 1'b0;
        end else begin
          tmr_reg <= tmr_reg - 1'b1;
        end
      end
      if (cs_rise) begin
        // commands act only on chip select release
        st_reg  <= ST_CMD;
        bit_reg <= 3'h0;
        nb_reg  <= 2'h0;
        rd_reg  <= 1'b0;
        if (!ers_reg && !prg_reg) begin
          case (pend_reg)
            PD_EN: begin
              sw_en_reg <= 1'b1;
            end
            PD_DIS: begin
              if (!wp_on)
                sw_en_reg <= 1'b0; // ignored while pin asserted
            end
            PD_ERS: begin
              if (!wp_on) begin // map locked by pin
                ers_reg <= 1'b1;
                tmr_reg <= ERASE_CYC[T_W-1:0] - 1'b1;
              end
            end
            default: begin
              if (st_reg == ST_PDAT && !wp_on) begin // allowed any software state
                prg_reg <= 1'b1;
                tmr_reg <= PROG_CYC[T_W-1:0] - 1'b1;
              end
            end
          endcase
        end
        pend_reg <= PD_NONE;
      end else if (cs_low && sck_rise) begin
        sh_reg  <= rx_next;
        bit_reg <= bit_reg + 1'b1;
        if (byte_done) begin
          case (st_reg)
            ST_CMD: begin
              nb_reg <= nb_reg + 1'b1;
              if (nb_reg == 2'h0) begin
                // opening byte: read opcode or protection prefix
                rd_reg <= (rx_next == `FSP_OP_READ);
                if (rx_next != `FSP_OP_READ && rx_next != `FSP_PFX0)
                  st_reg <= ST_IGN;
              end else if (rd_reg) begin
                // dummies may hold anything; map data follows the third
                if (nb_reg == 2'h3) begin
                  st_reg   <= ST_RDAT;
                  rptr_reg <= 3'h0;
                end
              end else begin
                case (nb_reg)
                  2'h1: begin
                    if (rx_next != `FSP_PFX1)
                      st_reg <= ST_IGN;
                  end
                  2'h2: begin
                    if (rx_next != `FSP_PFX2)
                      st_reg <= ST_IGN;
                  end
                  default: begin
                    // code byte; whatever follows a plain code is ignored
                    case (rx_next)
                      `FSP_CODE_ENABLE: begin
                        pend_reg <= PD_EN;
                        st_reg   <= ST_IGN;
                      end
                      `FSP_CODE_DISABLE: begin
                        pend_reg <= PD_DIS;
                        st_reg   <= ST_IGN;
                      end
                      `FSP_CODE_ERASE: begin
                        pend_reg <= PD_ERS;
                        st_reg   <= ST_IGN;
                      end
                      `FSP_CODE_PROGRAM: begin
                        st_reg   <= ST_PDAT;
                        wptr_reg <= 3'h0;
                      end
                      default: st_reg <= ST_IGN; // unknown code dropped
                    endcase
                  end
                endcase
              end
            end
            ST_PDAT: begin
              // data staged through buffer 1, pointer wraps at eight
              stage_reg[wptr_reg] <= rx_next;
              buf1_we_out   <= 1'b1;
              buf1_addr_out <= wptr_reg;
              buf1_data_out <= rx_next;
              wptr_reg      <= wptr_reg + 1'b1;
            end
            ST_RDAT: begin
              rptr_reg <= rptr_reg + 1'b1; // next map byte
            end
            default: begin
              st_reg <= st_reg;
            end
          endcase
        end
      end
    end
  end

  // serial out shifts on falling clock; floats when chip select high
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      out_reg     <= 8'h00;
      so_out      <= 1'b0;
      so_oe_b_out <= 1'b1;
    end else if (!cs_low || st_reg != ST_RDAT) begin
      so_oe_b_out <= 1'b1;
      out_reg     <= map_reg[0];
      so_out      <= 1'b0;
    end else if (sck_fall) begin
      so_oe_b_out <= 1'b0;
      if (bit_reg == 3'h0) begin
        // byte boundary: msb of the next map byte goes straight out
        so_out  <= map_reg[rptr_reg][7];
        out_reg <= {map_reg[rptr_reg][6:0], 1'b0};
      end else begin
        so_out  <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  // protection status and the sector check of a request
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      busy_out      <= 1'b0;
      prot_en_out   <= 1'b0;
      sect_prot_out <= 1'b0;
      map_lock_out  <= 1'b0;
    end else begin
      busy_out     <= ers_reg | prg_reg; // high exactly for the self-timed run
      prot_en_out  <= sw_en_reg | wp_on;
      map_lock_out <= wp_on;
      if (sect_req_in[2:0] != 3'h0)
        sect_prot_out <= (sw_en_reg | wp_on) & (map_reg[sect_req_in[2:0]] == `FSP_MAP_ERASED);
      else if (sub_req_in)
        sect_prot_out <= (sw_en_reg | wp_on)
                       & (map_reg[0][`FSP_SUB_B_HI:`FSP_SUB_B_LO] == 2'h3);
      else
        sect_prot_out <= (sw_en_reg | wp_on)
                       & (map_reg[0][`FSP_SUB_A_HI:`FSP_SUB_A_LO] == 2'h3);
    end
  end
endmodule
`default_nettype wire

/* tb/fsp_protect_asserts.sv */
// fsp_protect_asserts.sv: port-level checker for fsp_protect
// assumes: bound to fsp_protect, one clock mclk_in
`timescale 1ns/1ps
`default_nettype none
module fsp_protect_asserts #(
  parameter integer ERASE_CYC = 20,
  parameter integer PROG_CYC  = 20
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic wp_b_in,
  input wire logic so_oe_b_out,
  input wire logic busy_out,
  input wire logic prot_en_out,
  input wire logic sect_prot_out,
  input wire logic map_lock_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0]  lo_reg;
  logic [7:0]  hi_reg;
  logic [31:0] bz_reg;
  // run lengths of each pin level and of busy
  always @(posedge mclk_in) begin
    lo_reg <= (wp_b_in || !rst_b_in) ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
    hi_reg <= (!wp_b_in || !rst_b_in) ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hFF};
    bz_reg <= (busy_out && rst_b_in) ? bz_reg + 32'h1 : 32'h0;
  end
  property p_oe; cs_b_in [*7] |-> so_oe_b_out; endproperty
  a_oe: assert property (p_oe) else $error("so driven while deselected");
  property p_rise; $rose(map_lock_out) |-> lo_reg >= 8'h08; endproperty
  a_rise: assert property (p_rise) else $error("pin glitch locked the map");
  property p_on; lo_reg >= 8'h1E |-> map_lock_out && prot_en_out; endproperty
  a_on: assert property (p_on) else $error("pin low but no protection");
  property p_off; hi_reg >= 8'h1E |-> !map_lock_out; endproperty
  a_off: assert property (p_off) else $error("pin high but map locked");
  property p_lock; map_lock_out ##1 map_lock_out |-> prot_en_out; endproperty
  a_lock: assert property (p_lock) else $error("lock without protection");
  property p_sect; !prot_en_out ##1 !prot_en_out |-> !sect_prot_out; endproperty
  a_sect: assert property (p_sect) else $error("sector protected while disabled");
  property p_bcause; $rose(busy_out) |-> cs_b_in && $past(cs_b_in, 3); endproperty
  a_bcause: assert property (p_bcause) else $error("busy began inside a frame");
  property p_blen; $fell(busy_out) |-> bz_reg == ERASE_CYC || bz_reg == PROG_CYC; endproperty
  a_blen: assert property (p_blen) else $error("busy length wrong");
  c_lock: cover property (map_lock_out);
  c_busy: cover property ($fell(busy_out));
  c_read: cover property (!so_oe_b_out);
endmodule
`default_nettype wire

/* tb/fsp_spi_host.sv */
// fsp_spi_host.sv: spi host model issuing protection commands
// assumes: mode 0, driven on mclk_in falls, 10 mclk per sck half
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_host (
  input  wire logic mclk_in,
  input  wire logic so_in,
  output var  logic sck_out,
  output var  logic cs_b_out,
  output var  logic si_out
);
  integer i;
  // idle: deselected, clock still
  initial begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    si_out = 1'b0;
  end
  // select and settle before the first clock
  task start;
    begin
      cs_b_out = 1'b0;
      repeat (10) @(negedge mclk_in);
    end
  endtask
  // one byte each way, msb first, so taken at sck rise
  task xfer(input logic [7:0] d, output logic [7:0] q);
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si_out = d[i];
        repeat (10) @(negedge mclk_in);
        sck_out = 1'b1;
        q[i] = so_in;
        repeat (10) @(negedge mclk_in);
        sck_out = 1'b0;
      end
    end
  endtask
  // deselect; si stops holding the last bit
  task stop;
    begin
      repeat (10) @(negedge mclk_in);
      cs_b_out = 1'b1;
      si_out = ~si_out;
      repeat (12) @(negedge mclk_in);
    end
  endtask
endmodule
`default_nettype wire

/* tb/fsp_protect_bench.sv */
// fsp_protect_bench.sv: self-checking bench for fsp_protect
// assumes: fsp_spi_host on the serial side, short busy counts
`timescale 1ns/1ps
`default_nettype none
module fsp_protect_bench;
  logic        mclk_in, rst_b_in, wp_b_in, sub_req_in, sck_in, cs_b_in, si_in;
  logic        so_out, so_oe_b_out, busy_out, prot_en_out, sect_prot_out, map_lock_out, buf1_we_out;
  logic [3:0]  sect_req_in;
  logic [7:0]  q;
  logic [2:0]  buf1_addr_out, last_addr;
  logic [7:0]  buf1_data_out, last_data;
  logic [71:0] pd;
  integer      bad_count, checks, we_n, k;
  fsp_protect #(.ERASE_CYC(20), .PROG_CYC(20)) dut_u (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .sck_in(sck_in), .cs_b_in(cs_b_in), .si_in(si_in),
    .wp_b_in(wp_b_in), .sect_req_in(sect_req_in), .sub_req_in(sub_req_in), .so_out(so_out),
    .so_oe_b_out(so_oe_b_out), .busy_out(busy_out), .prot_en_out(prot_en_out),
    .sect_prot_out(sect_prot_out), .map_lock_out(map_lock_out), .buf1_we_out(buf1_we_out),
    .buf1_addr_out(buf1_addr_out), .buf1_data_out(buf1_data_out));
  fsp_spi_host host_u (.mclk_in(mclk_in), .so_in(so_out), .sck_out(sck_in), .cs_b_out(cs_b_in), .si_out(si_in));
  // clock and buffer-1 write counter
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (buf1_we_out === 1'b1) begin
      we_n = we_n + 1;
      last_addr = buf1_addr_out;
      last_data = buf1_data_out;
    end
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // four-byte protection command
  task cmd(input logic [7:0] c);
    begin
      host_u.start;
      host_u.xfer(8'h3D, q);
      host_u.xfer(8'h2A, q);
      host_u.xfer(8'h7F, q);
      host_u.xfer(c, q);
      host_u.stop;
    end
  endtask
  task en_is(input logic e);
    chk("prot_en", {7'h0, prot_en_out}, {7'h0, e});
  endtask
  // bounded wait for the self-timed cycle
  task idle;
    begin
      chk("busy", {7'h0, busy_out}, 8'h01);
      for (k = 0; k < 200 && busy_out !== 1'b0; k = k + 1) @(negedge mclk_in);
      chk("idle", {7'h0, busy_out}, 8'h00);
    end
  endtask
  // map read, then deselect floats so
  task rd(input logic [63:0] e);
    begin
      host_u.start;
      host_u.xfer(8'h32, q);
      repeat (3) host_u.xfer(8'h00, q);
      for (k = 0; k < 8; k = k + 1) begin
        host_u.xfer(8'h00, q);
        chk("map", q, e[63 - 8 * k -: 8]);
      end
      chk("so_on", {7'h0, so_oe_b_out}, 8'h00);
      host_u.stop;
      chk("so_off", {7'h0, so_oe_b_out}, 8'h01);
    end
  endtask
  task sect(input logic [3:0] s, input logic b, input logic e);
    begin
      sect_req_in = s;
      sub_req_in = b;
      repeat (3) @(negedge mclk_in);
      chk("sect", {7'h0, sect_prot_out}, {7'h0, e});
    end
  endtask
  task pin(input logic v, input integer n);
    begin
      wp_b_in = v;
      repeat (n) @(negedge mclk_in);
    end
  endtask
  // erase then program nine bytes, the ninth wrapping
  task t_map;
    begin
      cmd(8'hCF);
      idle;
      rd({8{8'hFF}});
      we_n = 0;
      pd = 72'hFF00FF00FF00FF0030;
      host_u.start;
      host_u.xfer(8'h3D, q);
      host_u.xfer(8'h2A, q);
      host_u.xfer(8'h7F, q);
      host_u.xfer(8'hFC, q);
      for (k = 0; k < 9; k = k + 1) host_u.xfer(pd[71 - 8 * k -: 8], q);
      host_u.stop;
      idle;
      chk("buf1", we_n[7:0], 8'h09);
      chk("buf1_addr", {5'h00, last_addr}, 8'h00);
      chk("buf1_data", last_data, 8'h30);
      rd(64'h3000FF00FF00FF00);
    end
  endtask
  // software enable, sector lookup, disable
  task t_soft;
    begin
      sect(4'h2, 1'b0, 1'b0);
      cmd(8'hA9);
      en_is(1'b1);
      sect(4'h1, 1'b0, 1'b0);
      sect(4'h2, 1'b0, 1'b1);
      sect(4'h0, 1'b0, 1'b0);
      sect(4'h0, 1'b1, 1'b1);
      cmd(8'h9A);
      en_is(1'b0);
    end
  endtask
  // pin glitch, hold, refused commands, release with and without enable
  task t_pin;
    begin
      pin(1'b0, 3);
      pin(1'b1, 30);
      en_is(1'b0);
      pin(1'b0, 40);
      en_is(1'b1);
      sect(4'h2, 1'b0, 1'b1);
      chk("lock", {7'h0, map_lock_out}, 8'h01);
      cmd(8'hCF);
      chk("locked", {7'h0, busy_out}, 8'h00);
      pin(1'b1, 40);
      en_is(1'b0);
      pin(1'b0, 40);
      cmd(8'hA9);
      cmd(8'h9A);
      pin(1'b1, 40);
      en_is(1'b1);
      cmd(8'h9A);
      en_is(1'b0);
      cmd(8'h55);
      en_is(1'b0);
      chk("unknown", {7'h0, busy_out}, 8'h00);
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk_in);
    bad_count = bad_count + 1;
    end_of_test;
  end
  initial begin
    bad_count = 0;
    checks = 0;
    we_n = 0;
    rst_b_in = 1'b0;
    wp_b_in = 1'b1;
    sect_req_in = 4'h0;
    sub_req_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    en_is(1'b0);
    rd(64'h0);
    t_map;
    t_soft;
    t_pin;
    end_of_test;
  end
endmodule
bind fsp_protect fsp_protect_asserts #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) asserts_u (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in), .wp_b_in(wp_b_in),
  .so_oe_b_out(so_oe_b_out), .busy_out(busy_out), .prot_en_out(prot_en_out),
  .sect_prot_out(sect_prot_out), .map_lock_out(map_lock_out));
`default_nettype wire
